//--- verilog/dfm_top.sv
// Drive fault monitor: warning codes, latched error codes, brake request
//
// The strobed register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module dfm_top #(
  parameter int TEMP_TIMEOUT_CYC = dfm_pkg::TEMP_TIMEOUT_CYC
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [dfm_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [dfm_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [dfm_pkg::DATA_W-1:0] reg_rdata,
  // Measurements from the controller clock domain
  input wire logic [31:0] i2t_accumulator,
  input wire logic [31:0] tracking_error,
  input wire logic signed [15:0] phase1_current,
  input wire logic signed [15:0] phase2_current,
  input wire logic [11:0] rail_volts,
  input wire logic signed [7:0] controller_temp,
  input wire logic temp_sample,
  input wire logic signed [15:0] current_offset,
  input wire logic [15:0] enc_amplitude,
  input wire logic motor_power_en,
  input wire logic interrupt_tick,
  // Asynchronous pins
  input wire logic thermostat_hot,
  input wire logic inrush_active,
  input wire logic power_low,
  input wire logic logic_supply_low,
  input wire logic [2:0] hall_in,
  input wire logic fieldbus_sync,
  // Status outputs
  output logic [3:0] warning_code,
  output logic [3:0] error_code,
  output logic brake_request
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation

  logic [dfm_pkg::SYNC_W-1:0] pins_async;
  logic [dfm_pkg::SYNC_W-1:0] pins;

  assign pins_async = {fieldbus_sync, hall_in, logic_supply_low, power_low,
                       inrush_active, thermostat_hot};

  dfm_sync u_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .async_in(pins_async),
    .sync_out(pins)
  );

  logic [2:0] hall_s;
  assign hall_s = pins[dfm_pkg::PIN_HALL_LO +: 3];

  ////////////////////////////////////////////////////////////////////////////
  // Register file

  logic brake_en_r, brake_en_nxt;
  logic [31:0] i2t_limit_r, i2t_limit_nxt;
  logic [31:0] tracking_error_limit_r, tracking_error_limit_nxt;
  logic [15:0] phase_overcurrent_limit_r, phase_overcurrent_limit_nxt;
  logic [19:0] overvoltage_limit_r, overvoltage_limit_nxt;
  logic [19:0] undervoltage_limit_r, undervoltage_limit_nxt;
  logic [15:0] controller_max_current_r, controller_max_current_nxt;
  logic [15:0] enc_amp_error_level_r, enc_amp_error_level_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic sw_clear_cmd, hardware_reset_command;
  logic [3:0] warn_r, warn_nxt;
  logic [3:0] err_r, err_nxt;
  logic brake_r, brake_nxt;
  logic sync_loss_r, sync_loss_nxt;
  logic temp_fail;

  // Commands are write pulses, not stored bits
  assign sw_clear_cmd = reg_wr && (reg_addr == dfm_pkg::REG_CMD) &&
                        reg_wdata[dfm_pkg::CMD_SW_CLEAR_BIT];
  assign hardware_reset_command = reg_wr && (reg_addr == dfm_pkg::REG_CMD) &&
                                  reg_wdata[dfm_pkg::CMD_HW_RESET_BIT];

  always_comb begin
    brake_en_nxt = brake_en_r;
    i2t_limit_nxt = i2t_limit_r;
    tracking_error_limit_nxt = tracking_error_limit_r;
    phase_overcurrent_limit_nxt = phase_overcurrent_limit_r;
    overvoltage_limit_nxt = overvoltage_limit_r;
    undervoltage_limit_nxt = undervoltage_limit_r;
    controller_max_current_nxt = controller_max_current_r;
    enc_amp_error_level_nxt = enc_amp_error_level_r;
    if (reg_wr) begin
      if (reg_addr == dfm_pkg::REG_CTRL) begin
        brake_en_nxt = reg_wdata[dfm_pkg::CTRL_BRAKE_EN_BIT];
      end else if (reg_addr == dfm_pkg::REG_I2T_LIMIT) begin
        i2t_limit_nxt = reg_wdata;
      end else if (reg_addr == dfm_pkg::REG_TRACKING_ERROR_LIMIT) begin
        tracking_error_limit_nxt = reg_wdata;
      end else if (reg_addr == dfm_pkg::REG_PHASE_OVERCURRENT_LIMIT) begin
        phase_overcurrent_limit_nxt = reg_wdata[15:0];
      end else if (reg_addr == dfm_pkg::REG_OVERVOLTAGE_LIMIT) begin
        overvoltage_limit_nxt = reg_wdata[19:0];
      end else if (reg_addr == dfm_pkg::REG_UNDERVOLTAGE_LIMIT) begin
        undervoltage_limit_nxt = reg_wdata[19:0];
      end else if (reg_addr == dfm_pkg::REG_CONTROLLER_MAX_CURRENT) begin
        controller_max_current_nxt = reg_wdata[15:0];
      end else if (reg_addr == dfm_pkg::REG_ENC_AMP_ERROR_LEVEL) begin
        enc_amp_error_level_nxt = reg_wdata[15:0];
      end
    end
    // Unmapped and write-only addresses read as zero
    rdata_nxt = 32'h0000_0000;
    if (reg_rd) begin
      if (reg_addr == dfm_pkg::REG_CTRL) begin
        rdata_nxt[dfm_pkg::CTRL_BRAKE_EN_BIT] = brake_en_r;
      end else if (reg_addr == dfm_pkg::REG_WARNING_CODE) begin
        rdata_nxt[3:0] = warn_r;
      end else if (reg_addr == dfm_pkg::REG_ERROR_CODE) begin
        rdata_nxt[3:0] = err_r;
      end else if (reg_addr == dfm_pkg::REG_STATUS) begin
        rdata_nxt[dfm_pkg::ST_BRAKE_BIT] = brake_r;
        rdata_nxt[dfm_pkg::ST_ERR_LATCHED_BIT] = (err_r != dfm_pkg::ERR_NONE);
        rdata_nxt[dfm_pkg::ST_SYNC_LOSS_BIT] = sync_loss_r;
        rdata_nxt[dfm_pkg::ST_TEMP_FAIL_BIT] = temp_fail;
      end else if (reg_addr == dfm_pkg::REG_I2T_LIMIT) begin
        rdata_nxt = i2t_limit_r;
      end else if (reg_addr == dfm_pkg::REG_TRACKING_ERROR_LIMIT) begin
        rdata_nxt = tracking_error_limit_r;
      end else if (reg_addr == dfm_pkg::REG_PHASE_OVERCURRENT_LIMIT) begin
        rdata_nxt[15:0] = phase_overcurrent_limit_r;
      end else if (reg_addr == dfm_pkg::REG_OVERVOLTAGE_LIMIT) begin
        rdata_nxt[19:0] = overvoltage_limit_r;
      end else if (reg_addr == dfm_pkg::REG_UNDERVOLTAGE_LIMIT) begin
        rdata_nxt[19:0] = undervoltage_limit_r;
      end else if (reg_addr == dfm_pkg::REG_CONTROLLER_MAX_CURRENT) begin
        rdata_nxt[15:0] = controller_max_current_r;
      end else if (reg_addr == dfm_pkg::REG_ENC_AMP_ERROR_LEVEL) begin
        rdata_nxt[15:0] = enc_amp_error_level_r;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      brake_en_r <= 1'b0;
      i2t_limit_r <= dfm_pkg::I2T_LIMIT_RST;
      tracking_error_limit_r <= dfm_pkg::TRACKING_ERROR_LIMIT_RST;
      phase_overcurrent_limit_r <= dfm_pkg::PHASE_OVERCURRENT_LIMIT_RST;
      overvoltage_limit_r <= dfm_pkg::OVERVOLTAGE_LIMIT_RST;
      undervoltage_limit_r <= dfm_pkg::UNDERVOLTAGE_LIMIT_RST;
      controller_max_current_r <= dfm_pkg::CONTROLLER_MAX_CURRENT_RST;
      enc_amp_error_level_r <= dfm_pkg::ENC_AMP_ERROR_LEVEL_RST;
      rdata_r <= 32'h0000_0000;
    end else begin
      brake_en_r <= brake_en_nxt;
      i2t_limit_r <= i2t_limit_nxt;
      tracking_error_limit_r <= tracking_error_limit_nxt;
      phase_overcurrent_limit_r <= phase_overcurrent_limit_nxt;
      overvoltage_limit_r <= overvoltage_limit_nxt;
      undervoltage_limit_r <= undervoltage_limit_nxt;
      controller_max_current_r <= controller_max_current_nxt;
      enc_amp_error_level_r <= enc_amp_error_level_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fieldbus sync watch and temperature sensor watchdog

  logic sync_prev_r, sync_prev_nxt;
  logic [1:0] tick_cnt_r, tick_cnt_nxt;
  logic [31:0] temp_cnt_r, temp_cnt_nxt;
  logic sync_rise;

  assign sync_rise = pins[dfm_pkg::PIN_FIELDBUS_SYNC] && !sync_prev_r;
  assign temp_fail = (temp_cnt_r >= unsigned'(TEMP_TIMEOUT_CYC));

  always_comb begin
    sync_prev_nxt = pins[dfm_pkg::PIN_FIELDBUS_SYNC];
    tick_cnt_nxt = tick_cnt_r;
    sync_loss_nxt = sync_loss_r;
    // Exactly one tick is expected per sync period
    if (sync_rise) begin
      sync_loss_nxt = (tick_cnt_r != dfm_pkg::TICKS_PER_SYNC);
      tick_cnt_nxt = interrupt_tick ? 2'h1 : 2'h0;
    end else if (interrupt_tick) begin
      if (tick_cnt_r == dfm_pkg::TICKS_PER_SYNC) begin
        sync_loss_nxt = 1'b1;
      end
      if (tick_cnt_r != 2'h3) begin
        tick_cnt_nxt = tick_cnt_r + 2'h1;
      end
    end
    temp_cnt_nxt = temp_cnt_r;
    if (temp_sample) begin
      temp_cnt_nxt = 32'h0000_0000;
    end else if (!temp_fail) begin
      temp_cnt_nxt = temp_cnt_r + 32'h0000_0001;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sync_prev_r <= 1'b0;
      tick_cnt_r <= 2'h0;
      sync_loss_r <= 1'b0;
      temp_cnt_r <= 32'h0000_0000;
    end else begin
      sync_prev_r <= sync_prev_nxt;
      tick_cnt_r <= tick_cnt_nxt;
      sync_loss_r <= sync_loss_nxt;
      temp_cnt_r <= temp_cnt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Limit comparisons

  logic [15:0] ph1_abs, ph2_abs, offs_abs;
  logic [19:0] volts_x100;
  logic [22:0] offs_x100, max_x8;
  logic [16:0] enc_level_x2;
  logic [15:0] warn_cond, err_cond;

  assign ph1_abs = phase1_current[15] ? 16'(-phase1_current) : phase1_current;
  assign ph2_abs = phase2_current[15] ? 16'(-phase2_current) : phase2_current;
  assign offs_abs = current_offset[15] ? 16'(-current_offset) : current_offset;
  // Scaling the measurement avoids a divider and keeps the limit exact
  assign volts_x100 = 20'(rail_volts) * dfm_pkg::VOLT_SCALE;
  assign offs_x100 = 23'(offs_abs) * dfm_pkg::OFFSET_SCALE;
  assign max_x8 = 23'(controller_max_current_r) * dfm_pkg::OFFSET_PCT;
  assign enc_level_x2 = {enc_amp_error_level_r, 1'b0};

  always_comb begin
    warn_cond = 16'h0000;
    warn_cond[dfm_pkg::WARN_I2T] = i2t_accumulator > (i2t_limit_r >> 1);
    warn_cond[dfm_pkg::WARN_TEMP] = 9'(controller_temp) > dfm_pkg::TEMP_WARN_DEG;
    warn_cond[dfm_pkg::WARN_POWER_LOW] = pins[dfm_pkg::PIN_POWER_LOW];
    warn_cond[dfm_pkg::WARN_ENC_AMP] = 17'(enc_amplitude) < enc_level_x2;
    warn_cond[dfm_pkg::WARN_TRACKING] =
      tracking_error > (tracking_error_limit_r >> 1);
    warn_cond[dfm_pkg::WARN_HALL] =
      (hall_s == dfm_pkg::HALL_BAD_LO) || (hall_s == dfm_pkg::HALL_BAD_HI);
    warn_cond[dfm_pkg::WARN_SYNC] = sync_loss_r;
    err_cond = 16'h0000;
    err_cond[dfm_pkg::ERR_OVERCURRENT1] = ph1_abs > phase_overcurrent_limit_r;
    err_cond[dfm_pkg::ERR_OVERCURRENT2] = ph2_abs > phase_overcurrent_limit_r;
    err_cond[dfm_pkg::ERR_I2T] = i2t_accumulator > i2t_limit_r;
    err_cond[dfm_pkg::ERR_OVERTEMP] = pins[dfm_pkg::PIN_THERMOSTAT];
    err_cond[dfm_pkg::ERR_OVERVOLTAGE] = volts_x100 > overvoltage_limit_r;
    err_cond[dfm_pkg::ERR_INRUSH] = motor_power_en &&
      (pins[dfm_pkg::PIN_INRUSH] || pins[dfm_pkg::PIN_POWER_LOW]);
    err_cond[dfm_pkg::ERR_LOGIC_SUPPLY] = pins[dfm_pkg::PIN_LOGIC_LOW];
    err_cond[dfm_pkg::ERR_UNDERVOLTAGE] = volts_x100 < undervoltage_limit_r;
    err_cond[dfm_pkg::ERR_CUR_OFFSET] = offs_x100 > max_x8;
    err_cond[dfm_pkg::ERR_TEMP_SENSOR] = temp_fail;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Code selection, latching and brake request

  logic [3:0] warn_pick, err_pick, err_base;
  logic clear_now;

  // Lowest active code wins; the loop runs downward so the last hit is lowest
  always_comb begin
    warn_pick = dfm_pkg::WARN_NONE;
    err_pick = dfm_pkg::ERR_NONE;
    for (int n = 15; n > 0; n--) begin
      if (warn_cond[n]) begin
        warn_pick = 4'(n);
      end
      if (err_cond[n]) begin
        err_pick = 4'(n);
      end
    end
  end

  always_comb begin
    warn_nxt = warn_pick;
    // Hardware reset clears every class, software clear only soft ones
    clear_now = hardware_reset_command ||
                (sw_clear_cmd && dfm_pkg::ERR_SOFT_MASK[err_r]);
    err_base = clear_now ? dfm_pkg::ERR_NONE : err_r;
    // A latched code is kept; a condition present at the clear relatches it
    err_nxt = (err_base == dfm_pkg::ERR_NONE) ? err_pick : err_base;
    brake_nxt = brake_en_r && (err_nxt != dfm_pkg::ERR_NONE) &&
                dfm_pkg::ERR_BRAKE_MASK[err_nxt];
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      warn_r <= dfm_pkg::WARN_NONE;
      err_r <= dfm_pkg::ERR_NONE;
      brake_r <= 1'b0;
    end else begin
      warn_r <= warn_nxt;
      err_r <= err_nxt;
      brake_r <= brake_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign warning_code = warn_r;
  assign error_code = err_r;
  assign brake_request = brake_r;

endmodule
`default_nettype wire

//--- inc/dfm_pkg.sv
// Package: constants, codes and register map of the drive fault monitor
package dfm_pkg;

  // Clock and timing
  localparam int SYS_CLK_HZ = 125000000;
  localparam int TEMP_TIMEOUT_MS = 100;
  localparam int TEMP_TIMEOUT_CYC = TEMP_TIMEOUT_MS * (SYS_CLK_HZ / 1000);

  // Bus widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register word addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h01;
  localparam logic [7:0] REG_WARNING_CODE = 8'h02;
  localparam logic [7:0] REG_ERROR_CODE = 8'h03;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_I2T_LIMIT = 8'h05;
  localparam logic [7:0] REG_TRACKING_ERROR_LIMIT = 8'h06;
  localparam logic [7:0] REG_PHASE_OVERCURRENT_LIMIT = 8'h07;
  localparam logic [7:0] REG_OVERVOLTAGE_LIMIT = 8'h08;
  localparam logic [7:0] REG_UNDERVOLTAGE_LIMIT = 8'h09;
  localparam logic [7:0] REG_CONTROLLER_MAX_CURRENT = 8'h0a;
  localparam logic [7:0] REG_ENC_AMP_ERROR_LEVEL = 8'h0b;

  // Field positions
  localparam int CTRL_BRAKE_EN_BIT = 0;
  localparam int CMD_SW_CLEAR_BIT = 0;
  localparam int CMD_HW_RESET_BIT = 1;
  localparam int ST_BRAKE_BIT = 0;
  localparam int ST_ERR_LATCHED_BIT = 1;
  localparam int ST_SYNC_LOSS_BIT = 2;
  localparam int ST_TEMP_FAIL_BIT = 3;

  // Reset values of the limit registers
  localparam logic [31:0] I2T_LIMIT_RST = 32'h0000_ffff;
  localparam logic [31:0] TRACKING_ERROR_LIMIT_RST = 32'h0000_1000;
  localparam logic [15:0] PHASE_OVERCURRENT_LIMIT_RST = 16'h7fff;
  localparam logic [19:0] OVERVOLTAGE_LIMIT_RST = 20'hfffff;
  localparam logic [19:0] UNDERVOLTAGE_LIMIT_RST = 20'h00000;
  localparam logic [15:0] CONTROLLER_MAX_CURRENT_RST = 16'h7fff;
  localparam logic [15:0] ENC_AMP_ERROR_LEVEL_RST = 16'h0000;

  // Thresholds
  localparam logic signed [8:0] TEMP_WARN_DEG = 9'sd65;
  localparam logic [19:0] VOLT_SCALE = 20'd100;
  localparam logic [22:0] OFFSET_SCALE = 23'd100;
  localparam logic [22:0] OFFSET_PCT = 23'd8;

  // Warning codes
  localparam logic [3:0] WARN_NONE = 4'h0;
  localparam logic [3:0] WARN_I2T = 4'h1;
  localparam logic [3:0] WARN_TEMP = 4'h2;
  localparam logic [3:0] WARN_POWER_LOW = 4'h3;
  localparam logic [3:0] WARN_ENC_AMP = 4'h5;
  localparam logic [3:0] WARN_TRACKING = 4'h6;
  localparam logic [3:0] WARN_HALL = 4'h8;
  localparam logic [3:0] WARN_SYNC = 4'h9;

  // Error codes
  localparam logic [3:0] ERR_NONE = 4'h0;
  localparam logic [3:0] ERR_OVERCURRENT1 = 4'h2;
  localparam logic [3:0] ERR_OVERCURRENT2 = 4'h3;
  localparam logic [3:0] ERR_I2T = 4'h4;
  localparam logic [3:0] ERR_OVERTEMP = 4'h5;
  localparam logic [3:0] ERR_OVERVOLTAGE = 4'h6;
  localparam logic [3:0] ERR_INRUSH = 4'h7;
  localparam logic [3:0] ERR_LOGIC_SUPPLY = 4'h8;
  localparam logic [3:0] ERR_UNDERVOLTAGE = 4'h9;
  localparam logic [3:0] ERR_CUR_OFFSET = 4'ha;
  localparam logic [3:0] ERR_TEMP_SENSOR = 4'hd;

  // Per-code class masks, bit n belongs to code n
  localparam logic [15:0] ERR_SOFT_MASK = 16'h22fc;
  localparam logic [15:0] ERR_BRAKE_MASK = 16'h03a0;

  // Synchronised pins
  localparam int SYNC_W = 8;
  localparam int PIN_THERMOSTAT = 0;
  localparam int PIN_INRUSH = 1;
  localparam int PIN_POWER_LOW = 2;
  localparam int PIN_LOGIC_LOW = 3;
  localparam int PIN_HALL_LO = 4;
  localparam int PIN_FIELDBUS_SYNC = 7;

  localparam logic [2:0] HALL_BAD_LO = 3'h0;
  localparam logic [2:0] HALL_BAD_HI = 3'h7;
  localparam logic [1:0] TICKS_PER_SYNC = 2'h1;

endpackage

//--- verilog/dfm_sync.sv
// Two-stage synchroniser for the asynchronous fault pins
`timescale 1ns/1ps
`default_nettype none
module dfm_sync (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [dfm_pkg::SYNC_W-1:0] async_in,
  output logic [dfm_pkg::SYNC_W-1:0] sync_out
);

  logic [dfm_pkg::SYNC_W-1:0] meta_r;
  logic [dfm_pkg::SYNC_W-1:0] sync_r;

  genvar i;
  generate
    for (i = 0; i < dfm_pkg::SYNC_W; i = i + 1) begin : g_bit
      always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
          meta_r[i] <= 1'b0;
          sync_r[i] <= 1'b0;
        end else begin
          meta_r[i] <= async_in[i];
          sync_r[i] <= meta_r[i];
        end
      end
    end
  endgenerate

  assign sync_out = sync_r;

endmodule
`default_nettype wire

//--- tb/dfm_top_properties.sv
// Checker: port-level properties of the drive fault monitor
`timescale 1ns/1ps
`default_nettype none
module dfm_top_checker (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [dfm_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [dfm_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic [31:0] i2t_accumulator,
  input wire logic signed [15:0] phase1_current,
  input wire logic signed [15:0] phase2_current,
  input wire logic signed [7:0] controller_temp,
  input wire logic [3:0] warning_code,
  input wire logic [3:0] error_code,
  input wire logic brake_request
);
  logic [31:0] lim_r;
  logic [31:0] lim_nxt;
  logic [15:0] ocl_r;
  logic [15:0] ocl_nxt;
  logic en_r;
  logic en_nxt;
  logic cmd_wr;
  logic cur_ok;
  logic i2t_warn;
  assign cmd_wr = reg_wr && reg_addr == dfm_pkg::REG_CMD;
  assign cur_ok = phase1_current == 16'sh0 && phase2_current == 16'sh0;
  assign i2t_warn = i2t_accumulator > (lim_r >> 1);
  // Shadow limits: the checker only sees the write port, not the registers
  always_comb begin
    lim_nxt = lim_r;
    ocl_nxt = ocl_r;
    en_nxt = en_r;
    if (!rst_n) begin
      lim_nxt = dfm_pkg::I2T_LIMIT_RST;
      ocl_nxt = dfm_pkg::PHASE_OVERCURRENT_LIMIT_RST;
      en_nxt = 1'b0;
    end else if (reg_wr && reg_addr == dfm_pkg::REG_I2T_LIMIT) begin
      lim_nxt = reg_wdata;
    end else if (reg_wr && reg_addr == dfm_pkg::REG_PHASE_OVERCURRENT_LIMIT) begin
      ocl_nxt = reg_wdata[15:0];
    end else if (reg_wr && reg_addr == dfm_pkg::REG_CTRL) begin
      en_nxt = reg_wdata[dfm_pkg::CTRL_BRAKE_EN_BIT];
    end
  end
  always_ff @(posedge sys_clk) begin
    lim_r <= lim_nxt;
    ocl_r <= ocl_nxt;
    en_r <= en_nxt;
  end
  //////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_hold;
    error_code != 4'h0 && !cmd_wr;
  endsequence
  a_i2t_warn: assert property (
    i2t_warn |=> warning_code == 4'h1) else $error("i2t warning missing");
  a_temp_warn: assert property (
    !i2t_warn && controller_temp > 8'sh41 |=> warning_code == 4'h2)
    else $error("temperature warning missing");
  a_phase1_trip: assert property (
    error_code == 4'h0 && !cmd_wr && !phase1_current[15] && !ocl_r[15] &&
    phase1_current[14:0] > ocl_r[14:0] |=> error_code == 4'h2)
    else $error("phase 1 overcurrent not latched");
  a_i2t_error: assert property (
    error_code == 4'h0 && !cmd_wr && cur_ok && i2t_accumulator > lim_r
    |=> error_code == 4'h4) else $error("i2t error not latched");
  a_err_hold: assert property (
    s_hold |=> $stable(error_code)) else $error("error code moved without a command");
  a_hard_kept: assert property (
    (error_code == 4'h8 || error_code == 4'ha) && cmd_wr && !reg_wdata[1]
    |=> $stable(error_code)) else $error("hard error cleared by soft command");
  a_soft_clear: assert property (
    error_code == 4'h4 && cmd_wr && reg_wdata[0] && i2t_accumulator <= lim_r
    |=> error_code != 4'h4) else $error("soft error not cleared");
  a_brake_class: assert property (
    en_r && $past(en_r) && error_code != 4'h0 && $stable(error_code)
    |-> brake_request == (error_code inside {4'h5, 4'h7, 4'h8, 4'h9}))
    else $error("brake request disagrees with error class");
  a_brake_idle: assert property (
    error_code == 4'h0 && $past(error_code) == 4'h0 |-> !brake_request)
    else $error("brake requested without error");
endmodule
bind dfm_top dfm_top_checker chk_i (.sys_clk(sys_clk), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .i2t_accumulator(i2t_accumulator), .phase1_current(phase1_current),
  .phase2_current(phase2_current), .controller_temp(controller_temp),
  .warning_code(warning_code), .error_code(error_code), .brake_request(brake_request));
`default_nettype wire

//--- tb/dfm_meas_src.sv
// Measurement side model: Hall pattern, fieldbus sync, interrupt tick, temp sensor
`timescale 1ns/1ps
`default_nettype none
module dfm_meas_src (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic hall_bad,
  input wire logic tick_skip,
  input wire logic temp_stop,
  output logic temp_sample,
  output logic interrupt_tick,
  output logic fieldbus_sync,
  output logic [2:0] hall_in
);
  logic [3:0] cnt_r = 4'h0;
  logic [2:0] hall_r = 3'h1;
  // Both Hall patterns are valid; all bits flip together so no glitch pattern
  always_ff @(posedge sys_clk) begin
    cnt_r <= rst_n ? cnt_r + 4'h1 : 4'h0;
    if (cnt_r == 4'hf)
      hall_r <= ~hall_r;
  end
  // Low in reset, so the first sync edge after release is a real one
  assign fieldbus_sync = cnt_r[3];
  assign interrupt_tick = cnt_r == 4'h4 && !tick_skip;
  assign temp_sample = cnt_r == 4'h8 && !temp_stop;
  assign hall_in = hall_bad ? 3'h7 : hall_r;
endmodule
`default_nettype wire

//--- tb/dfm_top_tb.sv
// Self-checking bench for the drive fault monitor
`timescale 1ns/1ps
`default_nettype none
module dfm_top_tb;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [31:0] i2t_accumulator = 32'h0;
  logic [31:0] tracking_error = 32'h0;
  logic signed [15:0] phase1_current = 16'sh0;
  logic signed [15:0] phase2_current = 16'sh0;
  logic [11:0] rail_volts = 12'h0f0;
  logic signed [7:0] controller_temp = 8'sh19;
  logic signed [15:0] current_offset = 16'sh0;
  logic [15:0] enc_amplitude = 16'h0400;
  logic motor_power_en = 1'b1;
  logic thermostat_hot = 1'b0;
  logic inrush_active = 1'b0;
  logic power_low = 1'b0;
  logic logic_supply_low = 1'b0;
  logic hall_bad = 1'b0;
  logic tick_skip = 1'b0;
  logic temp_stop = 1'b0;
  logic temp_sample;
  logic interrupt_tick;
  logic fieldbus_sync;
  logic [2:0] hall_in;
  logic [3:0] warning_code;
  logic [3:0] error_code;
  logic brake_request;
  int bad_count = 0;
  int num_checks = 0;
  localparam logic [3:0] ECODE [10] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9,
    4'ha, 4'hd};
  localparam logic [9:0] EBRK = 10'h0e8;
  localparam logic [9:0] EHARD = 10'h140;
  dfm_top #(.TEMP_TIMEOUT_CYC(50)) uut (.sys_clk(sys_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .i2t_accumulator(i2t_accumulator),
    .tracking_error(tracking_error), .phase1_current(phase1_current),
    .phase2_current(phase2_current), .rail_volts(rail_volts),
    .controller_temp(controller_temp), .temp_sample(temp_sample),
    .current_offset(current_offset), .enc_amplitude(enc_amplitude),
    .motor_power_en(motor_power_en), .interrupt_tick(interrupt_tick),
    .thermostat_hot(thermostat_hot), .inrush_active(inrush_active),
    .power_low(power_low), .logic_supply_low(logic_supply_low), .hall_in(hall_in),
    .fieldbus_sync(fieldbus_sync), .warning_code(warning_code),
    .error_code(error_code), .brake_request(brake_request));
  dfm_meas_src src (.sys_clk(sys_clk), .rst_n(rst_n), .hall_bad(hall_bad),
    .tick_skip(tick_skip), .temp_stop(temp_stop), .temp_sample(temp_sample),
    .interrupt_tick(interrupt_tick), .fieldbus_sync(fieldbus_sync), .hall_in(hall_in));
  initial forever #4 sys_clk = ~sys_clk;
  //////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wchk(input logic [3:0] e);
    cyc(5);
    chk("warning code", 32'(warning_code), 32'(e));
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(what, reg_rdata, exp);
  endtask
  task automatic set_cond(input int i, input logic on);
    @(posedge sys_clk);
    case (i)
      0: phase1_current <= on ? 16'sh1001 : 16'sh0;
      1: phase2_current <= on ? -16'sh1001 : 16'sh0;
      2: i2t_accumulator <= on ? 32'h0001_0000 : 32'h0;
      3: thermostat_hot <= on;
      4: rail_volts <= on ? 12'h12d : 12'h0f0;
      5: inrush_active <= on;
      6: logic_supply_low <= on;
      7: rail_volts <= on ? 12'h0c7 : 12'h0f0;
      8: current_offset <= on ? -16'sh0a3e : 16'sh0;
      default: temp_stop <= on;
    endcase
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    $display("watchdog expired");
    stop_test();
  end
  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    wr(dfm_pkg::REG_ERROR_CODE, 32'h5);
    rd(dfm_pkg::REG_ERROR_CODE, 32'h0, "read-only error reg");
    rd(8'h40, 32'h0, "unmapped reg");
    $display("test registers done");
    @(posedge sys_clk) i2t_accumulator <= 32'h0000_8000;
    wchk(4'h1);
    @(posedge sys_clk) i2t_accumulator <= 32'h0000_7fff;
    wchk(4'h0);
    @(posedge sys_clk) controller_temp <= 8'sh42;
    wchk(4'h2);
    @(posedge sys_clk) controller_temp <= 8'sh41;
    wchk(4'h0);
    @(posedge sys_clk) power_low <= 1'b1;
    wchk(4'h3);
    @(posedge sys_clk) power_low <= 1'b0;
    wr(dfm_pkg::REG_ENC_AMP_ERROR_LEVEL, 32'h100);
    @(posedge sys_clk) enc_amplitude <= 16'h01ff;
    wchk(4'h5);
    @(posedge sys_clk) enc_amplitude <= 16'h0200;
    wchk(4'h0);
    @(posedge sys_clk) tracking_error <= 32'h801;
    wchk(4'h6);
    @(posedge sys_clk) tracking_error <= 32'h800;
    wchk(4'h0);
    @(posedge sys_clk) hall_bad <= 1'b1;
    wchk(4'h8);
    @(posedge sys_clk) hall_bad <= 1'b0;
    @(posedge sys_clk) tick_skip <= 1'b1;
    cyc(40);
    rd(dfm_pkg::REG_WARNING_CODE, 32'h9, "warning reg");
    @(posedge sys_clk) tick_skip <= 1'b0;
    cyc(40);
    wchk(4'h0);
    chk("power low error", 32'(error_code), 32'h7);
    wr(dfm_pkg::REG_CMD, 32'h1);
    $display("test warnings done");
    wr(dfm_pkg::REG_CTRL, 32'h1);
    wr(dfm_pkg::REG_PHASE_OVERCURRENT_LIMIT, 32'h1000);
    wr(dfm_pkg::REG_OVERVOLTAGE_LIMIT, 32'h7530);
    wr(dfm_pkg::REG_UNDERVOLTAGE_LIMIT, 32'h4e20);
    for (int i = 0; i < 10; i++) begin
      set_cond(i, 1'b1);
      cyc(i == 9 ? 70 : 5);
      chk("error code", 32'(error_code), 32'(ECODE[i]));
      chk("brake", 32'(brake_request), 32'(EBRK[i]));
      set_cond(i, 1'b0);
      cyc(20);
      rd(dfm_pkg::REG_ERROR_CODE, 32'(ECODE[i]), "latched error reg");
      wr(dfm_pkg::REG_CMD, 32'h1);
      cyc(2);
      chk("after soft clear", 32'(error_code), EHARD[i] ? 32'(ECODE[i]) : 32'h0);
      wr(dfm_pkg::REG_CMD, 32'h2);
      cyc(2);
      chk("after hard clear", 32'(error_code), 32'h0);
    end
    $display("test errors done");
    // A latched code must not be displaced by a later, lower code
    set_cond(6, 1'b1);
    cyc(5);
    set_cond(0, 1'b1);
    cyc(5);
    chk("held code", 32'(error_code), 32'h8);
    rd(dfm_pkg::REG_STATUS, 32'h3, "status reg");
    wr(dfm_pkg::REG_CTRL, 32'h0);
    cyc(2);
    chk("brake disabled", 32'(brake_request), 32'h0);
    set_cond(6, 1'b0);
    set_cond(0, 1'b0);
    cyc(5);
    wr(dfm_pkg::REG_CMD, 32'h3);
    cyc(2);
    chk("both command bits", 32'(error_code), 32'h0);
    $display("test latching done");
    stop_test();
  end
endmodule
`default_nettype wire
